// file: wep_top.sv
// wake cause status, wake event output and ready flag
`timescale 1ns/1ps
`default_nettype none
`include "wep_consts.svh"
module wep_top #(
  parameter int unsigned PULSE_CYCLES = `WEP_PULSE_MS * `WEP_CLK_KHZ
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // host bus pins
  input wire logic [`WEP_ADDR_W-1:0] bus_addr,
  input wire logic bus_cs_n,
  input wire logic bus_rd_n,
  input wire logic bus_wr_n,
  input wire logic [`WEP_DATA_W-1:0] bus_data_in,
  output logic [`WEP_DATA_W-1:0] bus_data_out,
  output logic bus_data_oe,
  // device state from power control and detectors
  input wire logic device_stable,
  input wire logic [1:0] power_mode_field,
  input wire logic frame_wake_enable,
  input wire logic energy_wake_enable,
  input wire logic output_push_pull,
  input wire logic energy_event,
  input wire logic frame_event,
  input wire wep_pkg::wep_cause_t source_pending,
  // results
  output logic wake_event_output,
  output logic wake_event_output_oe,
  output logic wake_event_interrupt,
  output logic access_invalid,
  output logic ready_flag
);
  import wep_pkg::*;

  wep_timer_if tif ();

  // ****************************************
  // bus pin synchronisers and strobes
  // ****************************************
  logic [`WEP_ADDR_W-1:0] addr_s1, addr_s2;
  logic [`WEP_DATA_W-1:0] wdat_s1, wdat_s2;
  logic [2:0] ctl_s1, ctl_s2, ctl_s3;
  logic sel_pmc;
  logic sel_hwcfg;
  logic rd_edge;
  logic wr_edge;

  // two stages on every pin, a third on ctl for edges; ctl holds cs, rd, wr as active-high levels
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      addr_s1 <= '0;
      addr_s2 <= '0;
      wdat_s1 <= '0;
      wdat_s2 <= '0;
      ctl_s1 <= 3'h0;
      ctl_s2 <= 3'h0;
      ctl_s3 <= 3'h0;
    end else begin
      addr_s1 <= bus_addr;
      addr_s2 <= addr_s1;
      wdat_s1 <= bus_data_in;
      wdat_s2 <= wdat_s1;
      ctl_s1 <= {~bus_cs_n, ~bus_rd_n, ~bus_wr_n};
      ctl_s2 <= ctl_s1;
      ctl_s3 <= ctl_s2;
    end
  end

  // strobes fire once at the leading edge of a selected cycle
  assign rd_edge = ctl_s2[2] & ctl_s2[1] & ~(ctl_s3[2] & ctl_s3[1]);
  assign wr_edge = ctl_s2[2] & ctl_s2[0] & ~(ctl_s3[2] & ctl_s3[0]);
  assign sel_pmc = (addr_s2 == `WEP_PMC_OFFSET);
  assign sel_hwcfg = (addr_s2 == `WEP_HWCFG_OFFSET);

  // ****************************************
  // control register state
  // ****************************************
  logic out_en, next_out_en;
  logic polarity, next_polarity;
  logic pulse_sel, next_pulse_sel;
  wep_cause_t cause, next_cause;
  wep_cause_t clear_mask;
  wep_cause_t event_set;
  logic clear_ok;

  // events only latch when their wake source is enabled
  assign event_set = {frame_event & frame_wake_enable, energy_event & energy_wake_enable};
  // clears need full power with ready set
  assign clear_ok = wr_edge & sel_pmc & ready_flag
    & (power_mode_field == `WEP_MODE_FULL);
  // a bit whose sources still pend refuses the clear
  assign clear_mask = wdat_s2[`WEP_CAUSE_HI:`WEP_CAUSE_LO] & ~source_pending;

  // sticky causes: a new event in the clearing cycle wins over the clear
  always_comb begin
    next_out_en = out_en;
    next_polarity = polarity;
    next_pulse_sel = pulse_sel;
    next_cause = cause;
    if (wr_edge && sel_pmc) begin
      next_out_en = wdat_s2[`WEP_OUT_EN_BIT];
      next_polarity = wdat_s2[`WEP_POL_BIT];
      next_pulse_sel = wdat_s2[`WEP_PULSE_SEL_BIT];
    end
    if (clear_ok) begin
      next_cause = cause & ~clear_mask;
    end
    next_cause = next_cause | event_set;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      out_en <= 1'b0;
      polarity <= 1'b0;
      pulse_sel <= 1'b0;
      cause <= `WEP_CAUSE_NONE;
    end else begin
      out_en <= next_out_en;
      polarity <= next_polarity;
      pulse_sel <= next_pulse_sel;
      cause <= next_cause;
    end
  end

  // ****************************************
  // wake output sequencer
  // ****************************************
  wep_state_t state, next_state;
  logic deactivate;
  logic tmr_start;
  logic tmr_abort;

  // output drops once no enabled cause is left standing
  assign deactivate = ((next_cause & {frame_wake_enable, energy_wake_enable}) == 2'h0);

  always_comb begin
    next_state = state;
    tmr_start = 1'b0;
    tmr_abort = 1'b0;
    case (state)
      WEP_IDLE: begin
        if (event_set != 2'h0) begin
          if (pulse_sel) begin
            next_state = WEP_PULSE;
            tmr_start = 1'b1;
          end else begin
            next_state = WEP_STATIC;
          end
        end
      end
      WEP_PULSE: begin
        if (deactivate) begin
          next_state = WEP_IDLE;
          tmr_abort = 1'b1;
        end else if (tif.done) begin
          next_state = WEP_IDLE;
        end
      end
      WEP_STATIC: begin
        if (deactivate) begin
          next_state = WEP_IDLE;
        end
      end
      default: begin
        next_state = WEP_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= WEP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign tif.start = tmr_start;
  assign tif.abort = tmr_abort;

  wep_pulse_timer #(
    .PULSE_CYCLES(PULSE_CYCLES)
  ) u_timer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .tmr(tif.timer)
  );

  // ****************************************
  // pins, interrupt and bus answers
  // ****************************************
  logic active;
  logic next_pin, next_pin_oe, next_irq, next_invalid;
  logic [`WEP_DATA_W-1:0] next_rdata;
  logic next_rd_oe;

  assign active = out_en & (next_state != WEP_IDLE);

  always_comb begin
    if (output_push_pull) begin
      next_pin_oe = 1'b1;
      next_pin = active ? polarity : ~polarity;
    end else begin
      next_pin_oe = active; // wired-or low only
      next_pin = 1'b0;
    end
    // interrupt ignores the output enable
    next_irq = ((next_cause & {frame_wake_enable, energy_wake_enable}) != 2'h0);
    // before ready only control register accesses and configuration register reads are valid
    next_invalid = ~ready_flag & (rd_edge | wr_edge) & ~sel_pmc
      & ~(sel_hwcfg & rd_edge);
    next_rd_oe = ctl_s2[2] & ctl_s2[1] & sel_pmc;
    next_rdata = `WEP_RST_WORD;
    next_rdata[`WEP_CAUSE_HI:`WEP_CAUSE_LO] = cause;
    next_rdata[`WEP_PULSE_SEL_BIT] = pulse_sel;
    next_rdata[`WEP_POL_BIT] = polarity;
    next_rdata[`WEP_OUT_EN_BIT] = out_en;
    next_rdata[`WEP_READY_BIT] = ready_flag;
  end

  // every output from a flop; ready follows the stability input and full power mode by one cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wake_event_output <= 1'b0;
      wake_event_output_oe <= 1'b0;
      wake_event_interrupt <= 1'b0;
      access_invalid <= 1'b0;
      ready_flag <= 1'b0;
      bus_data_out <= `WEP_RST_WORD;
      bus_data_oe <= 1'b0;
    end else begin
      wake_event_output <= next_pin;
      wake_event_output_oe <= next_pin_oe;
      wake_event_interrupt <= next_irq;
      access_invalid <= next_invalid;
      ready_flag <= device_stable & (power_mode_field == `WEP_MODE_FULL);
      bus_data_out <= next_rdata;
      bus_data_oe <= next_rd_oe;
    end
  end
endmodule
`default_nettype wire

// file: wep_consts.svh
// constants for the wake event and power status block
// Operation
// - two-bit wake cause: none, energy, frame, multiple
// - writing one clears a cause bit; zero keeps
// - cause clears ignored until full power and ready
// - cause bit clears only once its sources cleared
// - pulse select set gives one 50 ms pulse
// - pulse select clear holds output until deactivated
// - clearing cause bits or enables deactivates output
// - polarity one active high, zero active low
// - open-drain ignores polarity, always active low
// - output asserts only while output enable set
// - output enable never gates the wake interrupt
// - control register readable in every power mode
// - other addresses invalid until ready flag set, except configuration register reads
// - power mode codes: full, frame/magic, energy, reserved
// - enabled event asserts output per pulse select
`ifndef WEP_CONSTS_SVH
`define WEP_CONSTS_SVH

// ****************************************
// register map
// ****************************************
`define WEP_ADDR_W 8
`define WEP_DATA_W 32
`define WEP_PMC_OFFSET 8'h84
`define WEP_HWCFG_OFFSET 8'h54
`define WEP_RST_WORD 32'h0000_0000

// ****************************************
// field positions in the control register
// ****************************************
`define WEP_READY_BIT 0
`define WEP_OUT_EN_BIT 1
`define WEP_POL_BIT 2
`define WEP_PULSE_SEL_BIT 3
`define WEP_CAUSE_LO 4
`define WEP_CAUSE_HI 5

// ****************************************
// cause and power mode codes
// ****************************************
`define WEP_CAUSE_NONE 2'h0
`define WEP_CAUSE_ENERGY 2'h1
`define WEP_CAUSE_FRAME 2'h2
`define WEP_MODE_FULL 2'h0
`define WEP_MODE_FRAME 2'h1
`define WEP_MODE_ENERGY 2'h2

// ****************************************
// timing
// ****************************************
`define WEP_PULSE_MS 50
`define WEP_CLK_KHZ 10000

`endif

// file: wep_pkg.sv
// types shared by the wake event and power status block
package wep_pkg;
  // one-hot states of the wake output sequencer
  typedef enum logic [2:0] {
    WEP_IDLE = 3'b001,
    WEP_PULSE = 3'b010,
    WEP_STATIC = 3'b100
  } wep_state_t;
  typedef logic [1:0] wep_cause_t;
endpackage

// file: wep_timer_if.sv
// handshake between the sequencer and the pulse timer
`timescale 1ns/1ps
`default_nettype none
interface wep_timer_if;
  logic start;
  logic abort;
  logic done;
  modport ctrl (output start, output abort, input done);
  modport timer (input start, input abort, output done);
endinterface
`default_nettype wire

// file: wep_pulse_timer.sv
// one-shot pulse length counter on the system clock
`timescale 1ns/1ps
`default_nettype none
module wep_pulse_timer #(
  parameter int unsigned PULSE_CYCLES = 500000
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // control
  wep_timer_if.timer tmr
);
  logic [31:0] count;
  logic [31:0] next_count;
  logic running;
  logic next_running;
  logic done;
  logic next_done;

  // refuse lengths the counter cannot hold, at elaboration rather than at run time
  if (PULSE_CYCLES < 1 || PULSE_CYCLES > 32'h7fff_ffff) begin
    $error("wep_pulse_timer: PULSE_CYCLES out of range");
  end

  // count down from the length; done is one cycle at the end
  always_comb begin
    next_count = count;
    next_running = running;
    next_done = 1'b0;
    if (tmr.abort) begin
      next_running = 1'b0;
    end else if (tmr.start) begin
      next_count = 32'(PULSE_CYCLES - 1);
      next_running = 1'b1;
    end else if (running) begin
      if (count == 32'h0) begin
        next_running = 1'b0;
        next_done = 1'b1;
      end else begin
        next_count = count - 32'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      count <= 32'h0;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      running <= next_running;
      done <= next_done;
    end
  end

  assign tmr.done = done;
endmodule
`default_nettype wire

// file: wep_top_asserts.sv
// checker on the wake event block ports
`timescale 1ns/1ps
`default_nettype none
`include "wep_consts.svh"
module wep_top_asserts #(
  parameter int unsigned PULSE_CYCLES = 20
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // host bus
  input wire logic [7:0] bus_addr,
  input wire logic bus_cs_n,
  input wire logic bus_rd_n,
  input wire logic bus_data_oe,
  // device side
  input wire logic device_stable,
  input wire logic [1:0] power_mode_field,
  input wire logic frame_wake_enable,
  input wire logic output_push_pull,
  input wire logic frame_event,
  input wire logic wake_event_output,
  input wire logic wake_event_interrupt,
  input wire logic access_invalid,
  input wire logic ready_flag
);
  // ****
  // port relations
  // ****
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // pins are async, so answers trail the strobes by a few edges
  wire logic rd_ctl = !bus_cs_n && !bus_rd_n && bus_addr == `WEP_PMC_OFFSET;
  wire logic bad = !bus_cs_n && bus_addr != `WEP_PMC_OFFSET && bus_addr != `WEP_HWCFG_OFFSET;
  open_drain_a: assert property (
    !output_push_pull && $stable(output_push_pull) |-> !wake_event_output)
    else $error("open drain pin high");
  frame_irq_a: assert property (
    frame_event && frame_wake_enable |-> ##[1:2] wake_event_interrupt)
    else $error("frame wake lost");
  ctl_read_a: assert property (
    rd_ctl [*5] |-> bus_data_oe)
    else $error("control read unanswered");
  read_cause_a: assert property (
    $rose(bus_data_oe) |-> $past(rd_ctl) && $past(rd_ctl, 2))
    else $error("read enable without read");
  read_end_a: assert property (
    $fell(rd_ctl) |-> ##[2:5] !bus_data_oe)
    else $error("read enable stuck");
  early_access_a: assert property (
    $rose(bad) && !ready_flag |-> ##[2:5] access_invalid)
    else $error("early access not flagged");
  invalid_pulse_a: assert property (
    access_invalid |-> !$past(bus_cs_n, 2) && $past(bus_addr, 2) != `WEP_PMC_OFFSET
      ##1 !access_invalid)
    else $error("stray invalid pulse");
  ready_mode_a: assert property (
    ready_flag |-> $past(device_stable) && $past(power_mode_field) == `WEP_MODE_FULL)
    else $error("ready outside full power");
endmodule
bind wep_top wep_top_asserts #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .bus_addr(bus_addr),
  .bus_cs_n(bus_cs_n),
  .bus_rd_n(bus_rd_n),
  .bus_data_oe(bus_data_oe),
  .device_stable(device_stable),
  .power_mode_field(power_mode_field),
  .frame_wake_enable(frame_wake_enable),
  .output_push_pull(output_push_pull),
  .frame_event(frame_event),
  .wake_event_output(wake_event_output),
  .wake_event_interrupt(wake_event_interrupt),
  .access_invalid(access_invalid),
  .ready_flag(ready_flag)
);
`default_nettype wire

// file: wep_host_model.sv
// host processor model for the register bus pins
`timescale 1ns/1ps
`default_nettype none
module wep_host_model (
  // clock
  input wire logic sys_clk,
  // bus pins
  output logic [7:0] bus_addr = 8'h00,
  output logic bus_cs_n = 1'b1,
  output logic bus_rd_n = 1'b1,
  output logic bus_wr_n = 1'b1,
  output logic [31:0] bus_data_in = 32'h0
);
  // ****
  // bus access
  // ****
  // six edges held, five released: covers the pin synchroniser both ways
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_data_in <= d;
    bus_cs_n <= 1'b0;
    bus_rd_n <= wr;
    bus_wr_n <= !wr;
    repeat (6) @(posedge sys_clk);
    bus_cs_n <= 1'b1;
    bus_rd_n <= 1'b1;
    bus_wr_n <= 1'b1;
    bus_addr <= ~a;  // a released bus keeps no old value
    bus_data_in <= ~d;
    repeat (5) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// self-checking bench for the wake event block
`timescale 1ns/1ps
`default_nettype none
`include "wep_consts.svh"
module tb_top;
  localparam int unsigned PC = 20;
  logic sys_clk, sys_rst, bus_cs_n, bus_rd_n, bus_wr_n, bus_data_oe, ready_flag;
  logic device_stable, frame_wake_enable, energy_wake_enable, output_push_pull;
  logic energy_event, frame_event, wake_event_output, wake_event_output_oe;
  logic wake_event_interrupt, access_invalid;
  logic oe_q = 1'b0;
  logic [7:0] bus_addr;
  logic [1:0] power_mode_field;
  logic [31:0] bus_data_in, bus_data_out, lfsr;
  logic [31:0] exp_q[$];
  wep_pkg::wep_cause_t source_pending;
  int n_errors = 0, cmp_count = 0, n_inv = 0, n;
  wep_top #(.PULSE_CYCLES(PC)) DUT (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .bus_addr(bus_addr),
    .bus_cs_n(bus_cs_n),
    .bus_rd_n(bus_rd_n),
    .bus_wr_n(bus_wr_n),
    .bus_data_in(bus_data_in),
    .bus_data_out(bus_data_out),
    .bus_data_oe(bus_data_oe),
    .device_stable(device_stable),
    .power_mode_field(power_mode_field),
    .frame_wake_enable(frame_wake_enable),
    .energy_wake_enable(energy_wake_enable),
    .output_push_pull(output_push_pull),
    .energy_event(energy_event),
    .frame_event(frame_event),
    .source_pending(source_pending),
    .wake_event_output(wake_event_output),
    .wake_event_output_oe(wake_event_output_oe),
    .wake_event_interrupt(wake_event_interrupt),
    .access_invalid(access_invalid),
    .ready_flag(ready_flag)
  );
  wep_host_model host (
    .sys_clk(sys_clk),
    .bus_addr(bus_addr),
    .bus_cs_n(bus_cs_n),
    .bus_rd_n(bus_rd_n),
    .bus_wr_n(bus_wr_n),
    .bus_data_in(bus_data_in)
  );
  // ****
  // helpers
  // ****
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // read words meet the oldest note as the read enable rises
  always @(posedge sys_clk) begin
    oe_q <= bus_data_oe;
    if (access_invalid === 1'b1) n_inv++;
    if (bus_data_oe === 1'b1 && oe_q !== 1'b1) chk(bus_data_out, exp_q.pop_front());
  end
  task automatic rd(input logic [31:0] e);
    exp_q.push_back(e);
    host.acc(1'b0, `WEP_PMC_OFFSET, lfsr);
  endtask
  // random upper bits prove the unused part of the word is ignored
  task automatic wr(input logic [7:0] d);
    lfsr = nxt(lfsr);
    host.acc(1'b1, `WEP_PMC_OFFSET, {lfsr[31:8], d});
  endtask
  task automatic fire(input logic fr);
    frame_event <= fr;
    energy_event <= !fr;
    @(posedge sys_clk);
    frame_event <= 1'b0;
    energy_event <= 1'b0;
  endtask
  // watchdog: the sequence needs well under 1000 cycles
  initial begin
    #(100 * 4000);
    n_errors++;
    report_and_stop();
  end
  // ****
  // scenarios
  // ****
  initial begin
    {device_stable, frame_wake_enable, energy_wake_enable, energy_event, frame_event} = '0;
    power_mode_field = `WEP_MODE_FULL;
    source_pending = 2'h0;
    output_push_pull = 1'b1;
    lfsr = 32'h8744;
    sys_rst = 1'b1;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // before ready only the control register and configuration register reads are open
    rd(32'h0);
    host.acc(1'b0, 8'h10, lfsr);
    host.acc(1'b0, `WEP_HWCFG_OFFSET, lfsr);
    chk(n_inv, 1);
    chk(ready_flag, 0);
    wr(8'h0e);
    device_stable <= 1'b1;
    frame_wake_enable <= 1'b1;
    energy_wake_enable <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk(ready_flag, 1);
    rd(32'h0f);
    $display("ready test done");
    // pulse mode, active high: one pulse of the set length
    fire(1'b1);
    n = 0;
    repeat (40) begin
      @(posedge sys_clk);
      n += int'(wake_event_output === 1'b1);
    end
    chk(n >= PC - 1 && n <= PC + 2, 1);
    chk(wake_event_interrupt, 1);
    fire(1'b0);
    rd(32'h3f);
    $display("pulse test done");
    // a pending source or low power blocks the clear; zero keeps a bit
    source_pending <= 2'h1;
    wr(8'h3e);
    rd(32'h1f);
    source_pending <= 2'h0;
    power_mode_field <= `WEP_MODE_FRAME;
    wr(8'h1e);
    rd(32'h1e);
    power_mode_field <= `WEP_MODE_FULL;
    wr(8'h0e);
    rd(32'h1f);
    wr(8'h1e);
    rd(32'h0f);
    chk(wake_event_interrupt, 0);
    $display("clear test done");
    // static, active low: held past a pulse length until the enable drops
    wr(8'h02);
    chk(wake_event_output, 1);
    fire(1'b1);
    repeat (3 * PC) @(posedge sys_clk);
    chk(wake_event_output, 0);
    frame_wake_enable <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(wake_event_output, 1);
    // output disabled: pin idle while the interrupt still follows
    wr(8'h20);
    frame_wake_enable <= 1'b1;
    fire(1'b1);
    repeat (3) @(posedge sys_clk);
    chk(wake_event_output, 1);
    chk(wake_event_interrupt, 1);
    output_push_pull <= 1'b0;
    wr(8'h06);
    chk(wake_event_output, 0);
    chk(wake_event_output_oe, 1);
    wr(8'h26);
    chk(wake_event_output_oe, 0);
    rd(32'h07);
    $display("output test done");
    // every noted read must have been answered
    chk(32'(exp_q.size()), 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
